// File: hdl/readout_pkg.sv
package readout_pkg;
  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 12;
  localparam int BIT_W = 5;
  localparam int CHAN_W = 2;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;
  localparam logic [CHAN_W-1:0] CHAN_STEP = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [BIT_W-1:0] BIT_ZERO = 5'h00;
  localparam logic [BIT_W-1:0] BIT_ONE = 5'h01;
  localparam logic [BIT_W-1:0] PULSE_COUNT = 5'h10;
  // ****************************************************************
  // timing, sys_clk at 125 MHz
  // ****************************************************************
  localparam int SYS_CLK_MHZ = 125;
  localparam int NS_PER_US = 1000;
  localparam int CONV_TIME_NS = 20000;
  localparam int ACQ_TIME_NS = 5000;
  localparam int CLK_DELAY_NS = 1400;
  localparam int CLK_PERIOD_NS = 1100;
  localparam int DATA_SETUP_NS = 20;
  localparam int RESULT_LEAD_NS = 20;
  localparam logic [CNT_W-1:0] CONV_CYC =
    CNT_W'(CONV_TIME_NS * SYS_CLK_MHZ / NS_PER_US);
  localparam logic [CNT_W-1:0] ACQ_CYC =
    CNT_W'(ACQ_TIME_NS * SYS_CLK_MHZ / NS_PER_US);
  localparam logic [CNT_W-1:0] CLK_DELAY_CYC =
    CNT_W'(CLK_DELAY_NS * SYS_CLK_MHZ / NS_PER_US);
  localparam logic [CNT_W-1:0] HALF_CYC =
    CNT_W'(CLK_PERIOD_NS * SYS_CLK_MHZ / (2 * NS_PER_US));
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((DATA_SETUP_NS * SYS_CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  // one extra cycle covers the byte bus register behind the result
  localparam logic [CNT_W-1:0] LEAD_CYC = CNT_W'(
    (RESULT_LEAD_NS * SYS_CLK_MHZ + NS_PER_US - 1) / NS_PER_US + 1);
  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic cs_n;
    logic read_convert;
    logic byte_select;
    logic output_path_select;
    logic bit_clock_source_select;
    logic continuous_scan_select;
    logic chain_in;
    logic channel_addr_hi;
    logic channel_addr_lo;
  } pins_t;
  localparam int PINS_W = $bits(pins_t);
  typedef enum {CONV_IDLE, CONV_RUN, CONV_LEAD, CONV_ACQ} conv_state_t;
  typedef enum {SCLK_IDLE, SCLK_DELAY, SCLK_LOW, SCLK_HIGH, SCLK_DONE}
    sclk_state_t;
endpackage : readout_pkg

// File: hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // ****************************************************************
  // two-stage synchroniser
  // ****************************************************************
  logic [WIDTH-1:0] meta_q;
  // meta_q feeds nothing but the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : pin_sync

// File: hdl/ext_shift.sv
`timescale 1ns/1ns
module ext_shift (
  input wire logic link_clk,
  input wire logic reset,
  input wire logic start_tgl,
  input wire logic [readout_pkg::RESULT_W-1:0] word,
  input wire logic chain_in,
  output logic serial_result_out_q,
  output logic frame_q
);
  import readout_pkg::*;
  // ****************************************************************
  // shifter on the host bit clock
  // ****************************************************************
  logic tgl_meta_q;
  logic tgl_s_q;
  logic tgl_seen_q;
  logic [RESULT_W-1:0] sr_q;
  wire logic start = tgl_s_q ^ tgl_seen_q;
  // toggle crossing; word is quasi-static, host keeps clock low at load
  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      tgl_meta_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_seen_q <= 1'b0;
    end
    else
    begin
      tgl_meta_q <= start_tgl;
      tgl_s_q <= tgl_meta_q;
      tgl_seen_q <= tgl_s_q;
    end
  end
  // frame edge loads the word, later edges shift chain bits behind it
  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      sr_q <= RESULT_RESET;
      serial_result_out_q <= 1'b0;
      frame_q <= 1'b0;
    end
    else if (start)
    begin
      sr_q <= word;
      frame_q <= 1'b1;
    end
    else
    begin
      frame_q <= 1'b0;
      serial_result_out_q <= sr_q[RESULT_W-1];
      sr_q <= {sr_q[RESULT_W-2:0], chain_in};
    end
  end
endmodule : ext_shift

// File: hdl/adc_result_readout_port.sv
`timescale 1ns/1ns
// ****************************************************************
// result readout port
// ****************************************************************
module adc_result_readout_port (
  input wire logic sys_clk,
  input wire logic reset,
  input wire readout_pkg::pins_t pin_in,
  input wire logic serial_bit_clock_i,
  input wire logic [readout_pkg::RESULT_W-1:0] core_result,
  output logic [readout_pkg::BYTE_W-1:0] result_byte_bus_o,
  output logic result_byte_bus_oe,
  output logic busy_n,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe,
  output logic serial_result_out_o,
  output logic serial_result_out_oe,
  output logic frame_pulse,
  output logic channel_addr_lo_o,
  output logic channel_addr_lo_oe,
  output logic channel_addr_hi_o,
  output logic channel_addr_hi_oe,
  output logic conv_start,
  output logic [readout_pkg::CHAN_W-1:0] conv_channel
);
  import readout_pkg::*;

  // ****************************************************************
  // pin sampling and edge events
  // ****************************************************************
  pins_t pins_s;
  logic or_low_q;
  logic read_en_q;

  // every control pin crosses two flops before use; chain_in does so on the internal path only
  pin_sync #(
    .WIDTH(PINS_W)
  ) u_pin_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(pin_in),
    .q(pins_s)
  );

  // selects and the or'd convert condition
  wire logic path_par = pins_s.output_path_select;
  wire logic ext_sel = pins_s.bit_clock_source_select;
  wire logic cont_sel = pins_s.continuous_scan_select;
  wire logic or_low = ~(pins_s.cs_n | pins_s.read_convert);
  wire logic read_en = ~pins_s.cs_n & pins_s.read_convert;
  wire logic conv_cmd = or_low & ~or_low_q;
  wire logic read_rise = read_en & ~read_en_q;
  wire logic int_serial = ~path_par & ~ext_sel;
  wire logic ext_serial = ~path_par & ext_sel;

  // previous levels for edge detection
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      // synced pins read all-low just after reset; starting high here
      // keeps that from looking like a fresh convert edge
      or_low_q <= 1'b1;
      read_en_q <= 1'b0;
    end
    else
    begin
      or_low_q <= or_low;
      read_en_q <= read_en;
    end
  end

  // ****************************************************************
  // conversion sequencing
  // ****************************************************************
  conv_state_t conv_q;
  conv_state_t conv_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic start_pulse;
  logic load_result;
  logic busy_rise;
  logic [RESULT_W-1:0] result_q;
  logic [CHAN_W-1:0] next_chan_q;

  wire logic cnt_zero = (cnt_q == CNT_ZERO);
  wire logic busy_low_d = (conv_d == CONV_RUN) | (conv_d == CONV_LEAD);

  // a convert command is only looked at while busy is high
  always_comb
  begin
    conv_d = conv_q;
    cnt_d = cnt_q;
    start_pulse = 1'b0;
    load_result = 1'b0;
    busy_rise = 1'b0;
    case (conv_q)
      CONV_IDLE:
      begin
        if (conv_cmd)
        begin
          start_pulse = 1'b1;
          conv_d = CONV_RUN;
          cnt_d = CONV_CYC - CNT_ONE;
        end
      end
      CONV_RUN:
      begin
        if (cnt_zero)
        begin
          load_result = 1'b1;
          conv_d = CONV_LEAD;
          cnt_d = LEAD_CYC - CNT_ONE;
        end
        else
        begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      CONV_LEAD:
      begin
        if (cnt_zero)
        begin
          busy_rise = 1'b1;
          conv_d = cont_sel ? CONV_ACQ : CONV_IDLE;
          cnt_d = ACQ_CYC - CNT_ONE;
        end
        else
        begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      CONV_ACQ:
      begin
        // continuous scan runs on while both inputs stay low
        if (cnt_zero)
        begin
          if (cont_sel & or_low)
          begin
            start_pulse = 1'b1;
            conv_d = CONV_RUN;
            cnt_d = CONV_CYC - CNT_ONE;
          end
          else
          begin
            conv_d = CONV_IDLE;
          end
        end
        else
        begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default:
      begin
        conv_d = CONV_IDLE;
      end
    endcase
  end

  // state, counter and busy; busy falls one cycle after the command
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      conv_q <= CONV_IDLE;
      cnt_q <= CNT_ZERO;
      busy_n <= 1'b1;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_q <= conv_d;
      cnt_q <= cnt_d;
      busy_n <= ~busy_low_d;
      conv_start <= start_pulse;
    end
  end

  // result word; old result stays readable until the load
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      result_q <= RESULT_RESET;
    end
    else if (load_result)
    begin
      result_q <= core_result;
    end
  end

  // ****************************************************************
  // channel address
  // ****************************************************************
  // manual: pins latched at start for the next conversion;
  // continuous: step at busy rise, driven out with busy
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      conv_channel <= CHAN_RESET;
      next_chan_q <= CHAN_RESET;
    end
    else if (start_pulse)
    begin
      conv_channel <= next_chan_q;
      if (!cont_sel)
      begin
        next_chan_q <= {pins_s.channel_addr_hi, pins_s.channel_addr_lo};
      end
    end
    else if (busy_rise & cont_sel)
    begin
      next_chan_q <= CHAN_W'(conv_channel + CHAN_STEP);
    end
  end

  assign channel_addr_lo_o = next_chan_q[0];
  assign channel_addr_hi_o = next_chan_q[1];

  // address pins become outputs only in continuous scan
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      channel_addr_lo_oe <= 1'b0;
      channel_addr_hi_oe <= 1'b0;
    end
    else
    begin
      channel_addr_lo_oe <= cont_sel;
      channel_addr_hi_oe <= cont_sel;
    end
  end

  // ****************************************************************
  // parallel byte bus
  // ****************************************************************
  wire logic [BYTE_W-1:0] byte_sel_d = pins_s.byte_select ?
    result_q[BYTE_W-1:0] : result_q[RESULT_W-1:BYTE_W];

  // three cycles from pin to bus keeps well inside access time
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      result_byte_bus_o <= BYTE_RESET;
      result_byte_bus_oe <= 1'b0;
    end
    else
    begin
      result_byte_bus_o <= byte_sel_d;
      result_byte_bus_oe <= path_par & read_en;
    end
  end

  // ****************************************************************
  // internal bit clock
  // ****************************************************************
  sclk_state_t sclk_q;
  sclk_state_t sclk_d;
  logic [CNT_W-1:0] sclk_cnt_q;
  logic [CNT_W-1:0] sclk_cnt_d;
  logic [BIT_W-1:0] bit_cnt_q;
  logic [BIT_W-1:0] bit_cnt_d;
  logic [RESULT_W-1:0] int_sr_q;
  logic int_serial_result_out_q;
  logic tag_q;

  wire logic sclk_zero = (sclk_cnt_q == CNT_ZERO);
  wire logic in_low = (sclk_q == SCLK_LOW);
  wire logic present = in_low & (sclk_cnt_q == SETUP_CYC);
  wire logic all_sent = (bit_cnt_q == PULSE_COUNT);
  wire logic take_tag = (sclk_d == SCLK_HIGH) & (sclk_q == SCLK_LOW) &
    (bit_cnt_q == BIT_ZERO);
  wire logic sclk_start = start_pulse & int_serial;

  // new bit set up a few cycles before each rise, held past the fall
  always_comb
  begin
    sclk_d = sclk_q;
    sclk_cnt_d = sclk_cnt_q;
    bit_cnt_d = bit_cnt_q;
    case (sclk_q)
      SCLK_IDLE, SCLK_DONE:
      begin
        if (sclk_start)
        begin
          sclk_d = SCLK_DELAY;
          sclk_cnt_d = CLK_DELAY_CYC - CNT_ONE;
          bit_cnt_d = BIT_ZERO;
        end
      end
      SCLK_DELAY:
      begin
        if (sclk_zero)
        begin
          sclk_d = SCLK_LOW;
          sclk_cnt_d = HALF_CYC - CNT_ONE;
        end
        else
        begin
          sclk_cnt_d = sclk_cnt_q - CNT_ONE;
        end
      end
      SCLK_LOW:
      begin
        if (sclk_zero)
        begin
          sclk_d = all_sent ? SCLK_DONE : SCLK_HIGH;
          sclk_cnt_d = HALF_CYC - CNT_ONE;
        end
        else
        begin
          sclk_cnt_d = sclk_cnt_q - CNT_ONE;
        end
      end
      SCLK_HIGH:
      begin
        if (sclk_zero)
        begin
          sclk_d = SCLK_LOW;
          sclk_cnt_d = HALF_CYC - CNT_ONE;
          bit_cnt_d = bit_cnt_q + BIT_ONE;
        end
        else
        begin
          sclk_cnt_d = sclk_cnt_q - CNT_ONE;
        end
      end
      default:
      begin
        sclk_d = SCLK_IDLE;
      end
    endcase
  end

  // clock generator state
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_q <= SCLK_IDLE;
      sclk_cnt_q <= CNT_ZERO;
      bit_cnt_q <= BIT_ZERO;
      serial_bit_clock_o <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_d;
      sclk_cnt_q <= sclk_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      serial_bit_clock_o <= (sclk_d == SCLK_HIGH);
    end
  end

  // shifter: previous result msb first, then the chain level
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      int_sr_q <= RESULT_RESET;
      int_serial_result_out_q <= 1'b0;
      tag_q <= 1'b0;
    end
    else
    begin
      if (sclk_start)
      begin
        int_sr_q <= result_q;
      end
      else if (present & !all_sent)
      begin
        int_serial_result_out_q <= int_sr_q[RESULT_W-1];
        int_sr_q <= {int_sr_q[RESULT_W-2:0], 1'b0};
      end
      else if (present)
      begin
        int_serial_result_out_q <= tag_q;
      end
      if (take_tag)
      begin
        tag_q <= pins_s.chain_in;
      end
    end
  end

  // ****************************************************************
  // external bit clock
  // ****************************************************************
  logic start_tgl_q;
  logic ext_serial_result_out;
  logic ext_frame;

  // a read enable edge in serial external mode opens a frame
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      start_tgl_q <= 1'b0;
    end
    else if (read_rise & ext_serial)
    begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // runs on the host clock; chain pin is sampled by that clock only
  ext_shift u_ext_shift (
    .link_clk(serial_bit_clock_i),
    .reset(reset),
    .start_tgl(start_tgl_q),
    .word(result_q),
    .chain_in(pin_in.chain_in),
    .serial_result_out_q(ext_serial_result_out),
    .frame_q(ext_frame)
  );

  // ****************************************************************
  // serial pin enables
  // ****************************************************************
  wire logic ser_oe_d = ~path_par &
    (ext_sel ? read_en : busy_low_d);

  // clock pin is an output only with the internal source
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      serial_bit_clock_oe <= 1'b0;
      serial_result_out_oe <= 1'b0;
    end
    else
    begin
      serial_bit_clock_oe <= int_serial;
      serial_result_out_oe <= ser_oe_d;
    end
  end

  // the external path mux is not registered: sys_clk adds no delay
  // to the host-clocked bit stream
  assign serial_result_out_o = ext_sel ? ext_serial_result_out : int_serial_result_out_q;
  assign frame_pulse = ext_sel & ext_frame;

endmodule : adc_result_readout_port

// File: sim/readout_properties.sv
`timescale 1ns/1ns
module readout_properties (
  input wire logic sys_clk,
  input wire logic reset,
  input wire readout_pkg::pins_t pin_in,
  input wire logic serial_bit_clock_i,
  input wire logic [readout_pkg::RESULT_W-1:0] core_result,
  input wire logic [readout_pkg::BYTE_W-1:0] result_byte_bus_o,
  input wire logic result_byte_bus_oe,
  input wire logic busy_n,
  input wire logic serial_bit_clock_o,
  input wire logic serial_bit_clock_oe,
  input wire logic serial_result_out_o,
  input wire logic serial_result_out_oe,
  input wire logic frame_pulse,
  input wire logic channel_addr_lo_o,
  input wire logic channel_addr_lo_oe,
  input wire logic channel_addr_hi_o,
  input wire logic channel_addr_hi_oe,
  input wire logic conv_start,
  input wire logic [readout_pkg::CHAN_W-1:0] conv_channel
);
  import readout_pkg::*;
  localparam int BUSY_CYC = int'(CONV_CYC) + int'(LEAD_CYC);
  logic bus_en, int_mode, ext_mode, ext_en, cont, clk_prev_q;
  logic [CNT_W-1:0] low_cnt_q;
  logic [BIT_W-1:0] rise_cnt_q;
  // ****************************************************************
  // pin decodes and helper counters
  // ****************************************************************
  // decodes on raw pins; the sequences below wait out the synchronisers
  assign bus_en = pin_in.output_path_select & ~pin_in.cs_n
    & pin_in.read_convert;
  assign int_mode = ~pin_in.output_path_select
    & ~pin_in.bit_clock_source_select;
  assign ext_mode = ~pin_in.output_path_select
    & pin_in.bit_clock_source_select;
  assign ext_en = ext_mode & ~pin_in.cs_n & pin_in.read_convert;
  assign cont = pin_in.continuous_scan_select;
  // busy low time and bit clock rises of one conversion
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      low_cnt_q <= CNT_ZERO;
      rise_cnt_q <= BIT_ZERO;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= busy_n ? CNT_ZERO : low_cnt_q + CNT_ONE;
      rise_cnt_q <= conv_start ? BIT_ZERO
        : rise_cnt_q + BIT_W'(serial_bit_clock_o & ~clk_prev_q);
      clk_prev_q <= serial_bit_clock_o;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_int;
    (int_mode && $stable(int_mode))[*4];
  endsequence
  sequence s_ext;
    (ext_mode && $stable({ext_mode, ext_en}))[*4];
  endsequence
  property p_bus_oe;
    $stable(bus_en)[*4] |-> result_byte_bus_oe == bus_en;
  endproperty
  property p_busy_fall;
    conv_start |-> !busy_n && $past(busy_n);
  endproperty
  property p_busy_len;
    $rose(busy_n) |-> low_cnt_q == BUSY_CYC;
  endproperty
  property p_int_oe;
    s_int |-> serial_result_out_oe == !busy_n && serial_bit_clock_oe
      && !frame_pulse;
  endproperty
  property p_ext_oe;
    s_ext |-> serial_result_out_oe == ext_en && !serial_bit_clock_oe;
  endproperty
  property p_pulses;
    s_int ##0 $rose(busy_n) |-> rise_cnt_q == PULSE_COUNT;
  endproperty
  property p_clk_idle;
    busy_n |-> !serial_bit_clock_o;
  endproperty
  property p_bit_hold;
    $changed(serial_bit_clock_o) |-> $stable(serial_result_out_o)[*2];
  endproperty
  property p_addr_oe;
    $stable(cont)[*4] |-> channel_addr_lo_oe == cont
      && channel_addr_hi_oe == cont;
  endproperty
  a_bus_oe: assert property (p_bus_oe)
    else $error("byte bus enable wrong");
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy not low with start");
  a_busy_len: assert property (p_busy_len)
    else $error("busy low time wrong");
  a_int_oe: assert property (p_int_oe)
    else $error("internal serial enables wrong");
  a_ext_oe: assert property (p_ext_oe)
    else $error("external serial enables wrong");
  a_pulses: assert property (p_pulses)
    else $error("bit clock pulse count wrong");
  a_clk_idle: assert property (p_clk_idle)
    else $error("bit clock not parked low");
  a_bit_hold: assert property (p_bit_hold)
    else $error("serial bit moved at clock edge");
  a_addr_oe: assert property (p_addr_oe)
    else $error("address enable wrong");
endmodule : readout_properties

// File: sim/link_host.sv
`timescale 1ns/1ns
module link_host (
  input wire logic run,
  output logic link_clk,
  input wire logic sdo,
  input wire logic frame,
  output logic [15:0] word,
  output logic [3:0] tail,
  output logic done
);
  int idx;
  // ****************************************************************
  // host bit clock, running only inside a read window
  // ****************************************************************
  initial
  begin
    link_clk = 1'b0;
    word = 16'h0000;
    tail = 4'h0;
    done = 1'b0;
    idx = -1;
  end
  // sample on the falling edge, away from the launching rise
  always @(posedge run)
  begin
    idx = -1;
    done = 1'b0;
    #30;
    repeat (40)
    begin
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
      if (idx >= 0 && idx < 16)
        word = {word[14:0], sdo};
      else if (idx >= 16 && idx < 20)
        tail = {tail[2:0], sdo};
      if (idx >= 0)
        idx++;
      else if (frame)
        idx = 0;
    end
    done = 1'b1;
  end
endmodule : link_host

// File: sim/adc_result_readout_port_tb.sv
`timescale 1ns/1ns
module adc_result_readout_port_tb;
  import readout_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic [RESULT_W-1:0] core_result = 16'h8C31;
  pins_t pin_in = '{cs_n: 1'b1, read_convert: 1'b1, output_path_select: 1'b1,
    chain_in: 1'b1, default: 1'b0};
  logic [BYTE_W-1:0] result_byte_bus_o;
  logic [CHAN_W-1:0] conv_channel, chan;
  logic [15:0] word, int_word;
  logic [3:0] tail;
  logic result_byte_bus_oe, busy_n, serial_bit_clock_o, serial_bit_clock_oe;
  logic serial_result_out_o, serial_result_out_oe, frame_pulse, conv_start;
  logic channel_addr_lo_o, channel_addr_lo_oe, channel_addr_hi_o;
  logic channel_addr_hi_oe, serial_bit_clock_i, done;
  int miscompares = 0;
  int n_compared = 0;
  int n_starts = 0;
  int int_cnt = 0;
  adc_result_readout_port dut (.*);
  link_host host (.run(run), .link_clk(serial_bit_clock_i),
    .sdo(serial_result_out_o), .frame(frame_pulse), .word(word),
    .tail(tail), .done(done));
  // ****************************************************************
  // clock, monitors and tasks
  // ****************************************************************
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (conv_start === 1'b1)
      n_starts++;
  // bits are taken at the rise, where they must already be settled
  always @(posedge serial_bit_clock_o)
  begin
    int_word = {int_word[14:0], serial_result_out_o};
    int_cnt++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic drive(input logic c, input logic r, input logic b);
    @(posedge sys_clk);
    pin_in.cs_n <= c;
    pin_in.read_convert <= r;
    pin_in.byte_select <= b;
  endtask : drive
  task automatic mode(input logic p, input logic s, input logic c);
    @(posedge sys_clk);
    pin_in.output_path_select <= p;
    pin_in.bit_clock_source_select <= s;
    pin_in.continuous_scan_select <= c;
  endtask : mode
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy_n !== lvl && k < 4000)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(16'(busy_n), 16'(lvl));
  endtask : wait_busy
  // start pulse, then read enable back high
  task automatic convert(input logic [15:0] res);
    int k;
    k = 0;
    drive(1'b0, 1'b0, 1'b0);
    core_result <= res;
    while (busy_n !== 1'b0 && k < 20)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(16'(k < 11), 16'h0001);
    drive(1'b0, 1'b1, 1'b0);
  endtask : convert
  // ten cycles stay inside the bus access time
  task automatic read_byte(input logic b, input logic [7:0] exp);
    drive(1'b0, 1'b1, b);
    repeat (10) @(posedge sys_clk);
    #1;
    check(16'(result_byte_bus_oe), 16'h0001);
    check({8'h00, result_byte_bus_o}, {8'h00, exp});
  endtask : read_byte
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check(16'(busy_n), 16'h0001);
    check(16'(result_byte_bus_oe), 16'h0000);
    $display("test reset done");
    convert(16'h8C31);
    wait_busy(1'b1);
    check({8'h00, result_byte_bus_o}, 16'h008C);
    read_byte(1'b1, 8'h31);
    read_byte(1'b0, 8'h8C);
    convert(16'h5A7E);
    read_byte(1'b0, 8'h8C);
    // a second command while busy must leave no trace
    drive(1'b0, 1'b0, 1'b0);
    drive(1'b0, 1'b1, 1'b1);
    wait_busy(1'b1);
    check(16'(n_starts), 16'h0002);
    read_byte(1'b1, 8'h7E);
    drive(1'b1, 1'b1, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1;
    check(16'(result_byte_bus_oe), 16'h0000);
    $display("test parallel done");
    mode(1'b0, 1'b0, 1'b0);
    repeat (5) @(posedge sys_clk);
    int_cnt = 0;
    convert(16'hC3A6);
    for (int k = 0; k < 3000 && int_cnt < 16; k++) @(posedge sys_clk);
    check(int_word, 16'h5A7E);
    // past the 16th high phase and the setup point of the 17th low
    repeat (150) @(posedge sys_clk);
    #1;
    check(16'({serial_result_out_oe, serial_result_out_o}), 16'h0003);
    wait_busy(1'b1);
    check(16'(serial_result_out_oe), 16'h0000);
    check(16'(int_cnt), 16'h0010);
    $display("test internal done");
    drive(1'b1, 1'b1, 1'b0);
    mode(1'b0, 1'b1, 1'b0);
    repeat (5) @(posedge sys_clk);
    drive(1'b0, 1'b1, 1'b0);
    run <= 1'b1;
    for (int k = 0; k < 200 && done !== 1'b1; k++) @(posedge sys_clk);
    run <= 1'b0;
    #1;
    check(word, 16'hC3A6);
    check(16'(tail), 16'h000F);
    check(16'(serial_result_out_oe), 16'h0001);
    drive(1'b1, 1'b1, 1'b0);
    repeat (10) @(posedge sys_clk);
    #1;
    check(16'(serial_result_out_oe), 16'h0000);
    $display("test external done");
    mode(1'b0, 1'b0, 1'b1);
    repeat (5) @(posedge sys_clk);
    drive(1'b0, 1'b0, 1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
    chan = {channel_addr_hi_o, channel_addr_lo_o};
    check(16'({channel_addr_hi_oe, channel_addr_lo_oe}), 16'h0003);
    wait_busy(1'b0);
    wait_busy(1'b1);
    check(16'({channel_addr_hi_o, channel_addr_lo_o}),
      {14'h0000, chan + CHAN_STEP});
    drive(1'b0, 1'b1, 1'b0);
    repeat (700) @(posedge sys_clk);
    #1;
    check(16'(busy_n), 16'h0001);
    $display("test continuous done");
    final_report();
  end
  // hang guard, well past the roughly 14000 cycles of the tests
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    $display("BAD at %0t seen %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  end
endmodule : adc_result_readout_port_tb

bind adc_result_readout_port readout_properties props (.*);
